/* include/crs_pkg.sv */
// constants and types for the register set and flags block
package crs_pkg;

  // memory space: one 64 Kbyte space, 16-bit addresses
  localparam int ADDR_W = 16;
  localparam int MEM_BYTES = 65536;

  // register byte offsets on the bus
  localparam logic [7:0] REG_IP = 8'h00;
  localparam logic [7:0] REG_ACC = 8'h04;
  localparam logic [7:0] REG_TMP = 8'h08;
  localparam logic [7:0] REG_IX = 8'h0C;
  localparam logic [7:0] REG_EP = 8'h10;
  localparam logic [7:0] REG_SP = 8'h14;
  localparam logic [7:0] REG_PS = 8'h18;
  localparam logic [7:0] REG_MIRROR = 8'h1C;
  localparam logic [7:0] REG_ALU = 8'h20;
  localparam logic [7:0] REG_DIR = 8'h24;
  localparam logic [7:0] REG_GP = 8'h28;
  localparam logic [7:0] REG_IRQ = 8'h2C;

  // data-space address of the bank/page mirror byte
  localparam logic [15:0] MIRROR_ADDR = 16'h0078;

  // status word field positions
  localparam int PS_RP_HI = 15;
  localparam int PS_RP_LO = 11;
  localparam int PS_DP_HI = 10;
  localparam int PS_DP_LO = 8;
  localparam int PS_CC_HI = 7;
  localparam int CC_H = 7;
  localparam int CC_I = 6;
  localparam int CC_IL_HI = 5;
  localparam int CC_IL_LO = 4;
  localparam int CC_N = 3;
  localparam int CC_Z = 2;
  localparam int CC_V = 1;
  localparam int CC_C = 0;

  // reset values: interrupts off, page 0, bank 0, level 3
  localparam logic [15:0] PS_RESET = 16'h0030;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // direct window and register bank layout
  localparam logic [7:0] DIR_WIN_LO = 8'h80;
  localparam int DIR_PAGE_SHIFT = 7;
  localparam logic [15:0] GP_BASE = 16'h0100;
  localparam int GP_IDX_W = 3;
  localparam int GP_BANKS = 32;

  // arithmetic operations that update the flags
  typedef enum logic [1:0] {ALU_ADD, ALU_SUB, ALU_SHL, ALU_SHR} crs_alu_op_t;

  // whole state of the block
  typedef struct packed {
    logic [15:0] ip;
    logic [15:0] acc;
    logic [15:0] tmp;
    logic [15:0] ix;
    logic [15:0] ep;
    logic [15:0] sp;
    logic [15:0] ps;
    logic [7:0] dirIn;
    logic [2:0] gpIdx;
    logic irqAcc;
    logic ack;
    logic [31:0] dat;
  } crs_state_t;

endpackage

/* logic/crs_regset.sv */
// programmer-visible register set, status word and flags of the core
////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - one 64 Kbyte space; every address formed here is 16 bits wide
// - 16-bit instruction pointer holds the fetch location
// - 16-bit accumulator; byte operations touch only its low byte
// - 16-bit temporary accumulator is the second operand, low byte for bytes
// - 16-bit index pointer, extra pointer and stack top pointer
// - status word: bank and page pointer high byte, flags low byte
// - direct 80h-FFh moves up 80h per page step, 111 gives 0400h-047Fh
// - direct 00h-7Fh always reach 0000h-007Fh unchanged
// - half-carry reflects carry or borrow between bits 3 and 4
// - interrupt enable permits when 1, blocks when 0, cleared by reset
// - request accepted only if its level is below the mask level
// - negative flag copies result msb
// - zero flag set for zero result, cleared otherwise
// - overflow flag set on two's-complement overflow
// - carry from bit 7 carry/borrow, or the bit shifted out
// - eight 8-bit registers per bank, 32 banks, index from 3 bits
// - bank pointer selects the active register bank
// - mirror byte shows bank and page pointers for memory access
module crs_regset
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic irqReq,
  input wire logic [1:0] irqLevel,
  output logic irqAccept,
  output logic [15:0] statusWord
);

  crs_pkg::crs_state_t st_r;
  crs_pkg::crs_state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////
  // helper functions

  // byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] laneMerge(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0] sel
  );
    logic [15:0] r;
    r = old;
    if (sel[0])
    begin
      r[7:0] = wd[7:0];
    end
    if (sel[1])
    begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // direct address to real address through the page selector
  function automatic logic [15:0] remapDirect(
    input logic [2:0] dp,
    input logic [7:0] da
  );
    logic [15:0] r;
    r = {8'h00, da};
    if (da >= crs_pkg::DIR_WIN_LO)
    begin
      r = r + (16'({13'h0000, dp}) << crs_pkg::DIR_PAGE_SHIFT);
    end
    return r;
  endfunction

  // bank and index to real address of a general register
  function automatic logic [15:0] gpAddr(
    input logic [4:0] rp,
    input logic [2:0] idx
  );
    return crs_pkg::GP_BASE + {8'h00, rp, idx};
  endfunction

  // flag update and byte result of an arithmetic operation
  function automatic logic [15:0] aluCalc(
    input crs_pkg::crs_alu_op_t op,
    input logic [7:0] a,
    input logic [7:0] b,
    input logic [7:0] cc
  );
    logic [8:0] s;
    logic [4:0] hs;
    logic [7:0] f;
    s = {1'b0, a};
    hs = 5'h00;
    f = cc;
    case (op)
      crs_pkg::ALU_ADD:
      begin
        s = {1'b0, a} + {1'b0, b};
        hs = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        f[crs_pkg::CC_H] = hs[4];
        f[crs_pkg::CC_V] = (a[7] == b[7]) && (s[7] != a[7]);
      end
      crs_pkg::ALU_SUB:
      begin
        s = {1'b0, a} - {1'b0, b};
        hs = {1'b0, a[3:0]} - {1'b0, b[3:0]};
        f[crs_pkg::CC_H] = hs[4];
        f[crs_pkg::CC_V] = (a[7] != b[7]) && (s[7] != a[7]);
      end
      crs_pkg::ALU_SHL:
      begin
        s = {a, 1'b0};
      end
      crs_pkg::ALU_SHR:
      begin
        s = {a[0], 1'b0, a[7:1]};
      end
      default:
      begin
        s = {1'b0, a};
      end
    endcase
    f[crs_pkg::CC_N] = s[7];
    f[crs_pkg::CC_Z] = (s[7:0] == 8'h00);
    f[crs_pkg::CC_C] = s[8];
    return {f, s[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // decoded views of the state

  logic [4:0] bankPtr;
  logic [2:0] pageSel;
  logic [1:0] maskLevel;
  logic [15:0] dirMapped;
  logic [15:0] gpMapped;
  logic reqNew;
  logic wrNow;
  logic [31:0] rdData;
  logic [15:0] aluOut;

  // status word fields and address formers
  assign bankPtr = st_r.ps[crs_pkg::PS_RP_HI:crs_pkg::PS_RP_LO];
  assign pageSel = st_r.ps[crs_pkg::PS_DP_HI:crs_pkg::PS_DP_LO];
  assign maskLevel = st_r.ps[crs_pkg::CC_IL_HI:crs_pkg::CC_IL_LO];
  assign dirMapped = remapDirect(pageSel, st_r.dirIn);
  assign gpMapped = gpAddr(bankPtr, st_r.gpIdx);
  assign aluOut = aluCalc(crs_pkg::crs_alu_op_t'(dat_i[1:0]),
    st_r.acc[7:0], st_r.tmp[7:0], st_r.ps[7:0]);

  // a new request is answered next cycle; writes land on the ack edge
  assign reqNew = cyc_i && stb_i && !st_r.ack;
  assign wrNow = cyc_i && stb_i && we_i && st_r.ack;

  // read mux; unmapped offsets read zero
  always_comb
  begin
    rdData = 32'h0000_0000;
    case (adr_i)
      crs_pkg::REG_IP: rdData = {16'h0000, st_r.ip};
      crs_pkg::REG_ACC: rdData = {16'h0000, st_r.acc};
      crs_pkg::REG_TMP: rdData = {16'h0000, st_r.tmp};
      crs_pkg::REG_IX: rdData = {16'h0000, st_r.ix};
      crs_pkg::REG_EP: rdData = {16'h0000, st_r.ep};
      crs_pkg::REG_SP: rdData = {16'h0000, st_r.sp};
      crs_pkg::REG_PS: rdData = {16'h0000, st_r.ps};
      crs_pkg::REG_MIRROR: rdData = {24'h00_0000, st_r.ps[15:8]};
      crs_pkg::REG_ALU: rdData = {24'h00_0000, st_r.ps[7:0]};
      crs_pkg::REG_DIR: rdData = {dirMapped, 8'h00, st_r.dirIn};
      crs_pkg::REG_GP: rdData = {gpMapped, 13'h0000, st_r.gpIdx};
      crs_pkg::REG_IRQ: rdData = {31'h0000_0000, st_r.irqAcc};
      default: rdData = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ack = reqNew;
    if (reqNew)
    begin
      st_nxt.dat = rdData;
    end
    // accept only when enabled and strictly more urgent than the mask
    st_nxt.irqAcc = irqReq && st_r.ps[crs_pkg::CC_I]
      && (irqLevel < maskLevel);
    if (wrNow)
    begin
      case (adr_i)
        crs_pkg::REG_IP: st_nxt.ip = laneMerge(st_r.ip, dat_i, sel_i);
        crs_pkg::REG_ACC: st_nxt.acc = laneMerge(st_r.acc, dat_i, sel_i);
        crs_pkg::REG_TMP: st_nxt.tmp = laneMerge(st_r.tmp, dat_i, sel_i);
        crs_pkg::REG_IX: st_nxt.ix = laneMerge(st_r.ix, dat_i, sel_i);
        crs_pkg::REG_EP: st_nxt.ep = laneMerge(st_r.ep, dat_i, sel_i);
        crs_pkg::REG_SP: st_nxt.sp = laneMerge(st_r.sp, dat_i, sel_i);
        crs_pkg::REG_PS: st_nxt.ps = laneMerge(st_r.ps, dat_i, sel_i);
        crs_pkg::REG_MIRROR:
        begin
          if (sel_i[0])
          begin
            st_nxt.ps[15:8] = dat_i[7:0];
          end
        end
        crs_pkg::REG_ALU:
        begin
          if (sel_i[0])
          begin
            st_nxt.acc[7:0] = aluOut[7:0];
            st_nxt.ps[7:0] = aluOut[15:8];
          end
        end
        crs_pkg::REG_DIR:
        begin
          if (sel_i[0])
          begin
            st_nxt.dirIn = dat_i[7:0];
          end
        end
        crs_pkg::REG_GP:
        begin
          if (sel_i[0])
          begin
            st_nxt.gpIdx = dat_i[2:0];
          end
        end
        default:
        begin
          st_nxt.dirIn = st_r.dirIn;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_r <= '0;
      st_r.ps <= crs_pkg::PS_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs from the state register
  assign dat_o = st_r.dat;
  assign ack_o = st_r.ack;
  assign irqAccept = st_r.irqAcc;
  assign statusWord = st_r.ps;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence aluStart;
    wrNow && (adr_i == crs_pkg::REG_ALU) && sel_i[0];
  endsequence

  sequence addZero;
    aluStart ##0 (dat_i[1:0] == 2'h0)
      && ((st_r.acc[7:0] + st_r.tmp[7:0]) == 8'h00);
  endsequence

  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  chk_ack_answer: assert property (reqNew |=> ack_o)
    else $error("request not answered in one cycle");

  chk_ie_reset: assert property (
    $rose(nrst) |-> !statusWord[crs_pkg::CC_I])
    else $error("interrupt enable not clear after reset");

  chk_irq_blocked: assert property (
    (!statusWord[crs_pkg::CC_I] || irqLevel >= maskLevel) |=> !irqAccept)
    else $error("request accepted while blocked");

  chk_low_direct: assert property (
    (st_r.dirIn < crs_pkg::DIR_WIN_LO) |-> dirMapped == {8'h00, st_r.dirIn})
    else $error("low direct address was remapped");

  chk_top_page: assert property (
    (pageSel == 3'h7 && st_r.dirIn == 8'hFF) |-> dirMapped == 16'h047F)
    else $error("page seven window end wrong");

  chk_gp_range: assert property (
    gpMapped >= crs_pkg::GP_BASE && gpMapped <= 16'h01FF
      && gpMapped[2:0] == st_r.gpIdx)
    else $error("register address out of bank area");

  chk_zero_flag: assert property (
    addZero |=> statusWord[crs_pkg::CC_Z])
    else $error("zero flag not set for zero sum");

  chk_high_kept: assert property (
    aluStart |=> st_r.acc[15:8] == $past(st_r.acc[15:8]))
    else $error("byte operation changed high byte");

  chk_neg_copy: assert property (
    aluStart |=> statusWord[crs_pkg::CC_N] == st_r.acc[7])
    else $error("negative flag differs from result msb");

  ////////////////////////////////////////////////////////////////////////
  // reference values for the flag and bus checks, kept apart from aluCalc

  logic [8:0] addRef;
  logic [4:0] halfRef;
  logic addCarry;
  logic addHalf;
  logic addOvf;
  logic shlOut;
  logic [15:0] wrWord;
  logic [7:0] bankPage;

  // byte sum and low-nibble sum of the two operands
  assign addRef = {1'b0, st_r.acc[7:0]} + {1'b0, st_r.tmp[7:0]};
  assign halfRef = {1'b0, st_r.acc[3:0]} + {1'b0, st_r.tmp[3:0]};

  // expected add flags, shifted-out bit, write word and mirror byte
  assign addCarry = addRef[8];
  assign addHalf = halfRef[4];
  assign addOvf = (st_r.acc[7] == st_r.tmp[7]) && (addRef[7] != st_r.acc[7]);
  assign shlOut = st_r.acc[7];
  assign wrWord = dat_i[15:0];
  assign bankPage = {bankPtr, pageSel};

  sequence aluAdd;
    aluStart ##0 (dat_i[1:0] == crs_pkg::ALU_ADD);
  endsequence

  sequence aluShiftLeft;
    aluStart ##0 (dat_i[1:0] == crs_pkg::ALU_SHL);
  endsequence

  chk_add_carry: assert property (
    aluAdd |=> statusWord[crs_pkg::CC_C] == $past(addCarry))
    else $error("carry flag wrong after add");

  chk_add_half: assert property (
    aluAdd |=> statusWord[crs_pkg::CC_H] == $past(addHalf))
    else $error("half-carry flag wrong after add");

  chk_add_ovf: assert property (
    aluAdd |=> statusWord[crs_pkg::CC_V] == $past(addOvf))
    else $error("overflow flag wrong after add");

  chk_shl_carry: assert property (
    aluShiftLeft |=> statusWord[crs_pkg::CC_C] == $past(shlOut))
    else $error("carry flag is not the bit shifted out");

  chk_ip_write: assert property (
    (wrNow && adr_i == crs_pkg::REG_IP && sel_i[1:0] == 2'h3)
      |=> st_r.ip == $past(wrWord))
    else $error("instruction pointer write lost");

  chk_mirror_read: assert property (
    (reqNew && !we_i && adr_i == crs_pkg::REG_MIRROR)
      |=> dat_o[7:0] == $past(bankPage))
    else $error("mirror byte differs from status word");

  chk_ps_quiet: assert property (
    !wrNow |=> $stable(statusWord))
    else $error("status word changed without a write");

  chk_irq_taken: assert property (
    (irqReq && statusWord[crs_pkg::CC_I] && irqLevel < maskLevel)
      |=> irqAccept)
    else $error("enabled request above mask refused");

  chk_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without a request");

endmodule // crs_regset

/* verif/crs_regset_tb.sv */
// self-checking bench for the register set and flags block
module crs_regset_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, cyc, stb, we, ack, irqReq, irqAccept;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] datI, datO, q;
  logic [1:0] irqLevel;
  logic [15:0] statusWord;
  int miscompares, total_checks, cycles;
  crs_regset crs_regset_inst (.clk(clk), .nrst(nrst), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datI),
    .dat_o(datO), .ack_o(ack), .irqReq(irqReq), .irqLevel(irqLevel),
    .irqAccept(irqAccept), .statusWord(statusWord));
  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // compare, bus cycle and verdict
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    datI <= d;
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'h1);
    q = datO;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    @(posedge clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    wb(1'h1, crs_pkg::REG_PS, 32'hFF4F);
    wb(1'h1, crs_pkg::REG_ACC, 32'h1234);
    chk("preset", 32'hFF4F, {16'h0, statusWord});
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    wb(1'h0, crs_pkg::REG_PS, 32'h0);
    chk("status", 32'h30, q);
    chk("statusWord", 32'h30, {16'h0, statusWord});
    wb(1'h0, crs_pkg::REG_ACC, 32'h0);
    chk("acc", 32'h0, q);
    wb(1'h0, 8'h30, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
  endtask
  task automatic t_regs();
    logic [7:0] o[6];
    o = '{crs_pkg::REG_IP, crs_pkg::REG_ACC, crs_pkg::REG_TMP,
          crs_pkg::REG_IX, crs_pkg::REG_EP, crs_pkg::REG_SP};
    for (int i = 0; i < 6; i++)
      wb(1'h1, o[i], 32'hFFFF_A5C0 | 32'(i));
    for (int i = 0; i < 6; i++)
    begin
      wb(1'h0, o[i], 32'h0);
      chk("word", 32'h0000_A5C0 | 32'(i), q);
    end
    $display("test regs done");
  endtask
  task automatic t_alu();
    logic [7:0] a[6], b[6], r[6], f[6];
    logic [1:0] op[6];
    a = '{8'hFF, 8'h7F, 8'h10, 8'h00, 8'h81, 8'h01};
    b = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
    op = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    r = '{8'h00, 8'h80, 8'h0F, 8'hFF, 8'h02, 8'h00};
    f = '{8'h85, 8'h8A, 8'h80, 8'h89, 8'h81, 8'h85};
    wb(1'h1, crs_pkg::REG_PS, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      wb(1'h1, crs_pkg::REG_ACC, {16'h0, 8'h12, a[i]});
      wb(1'h1, crs_pkg::REG_TMP, {24'h0, b[i]});
      wb(1'h1, crs_pkg::REG_ALU, {30'h0, op[i]});
      wb(1'h0, crs_pkg::REG_ALU, 32'h0);
      chk("flags", {24'h0, f[i]}, {24'h0, q[7:0]});
      wb(1'h0, crs_pkg::REG_ACC, 32'h0);
      chk("result", {16'h0, 8'h12, r[i]}, q);
    end
    $display("test alu done");
  endtask
  task automatic t_dir();
    logic [7:0] d;
    for (int p = 0; p < 8; p++)
      for (int k = 0; k < 2; k++)
      begin
        d = k ? 8'hFF : 8'h7F;
        wb(1'h1, crs_pkg::REG_PS, 32'(p) << 8);
        chk("page", 32'(p), {29'h0, statusWord[10:8]});
        wb(1'h1, crs_pkg::REG_DIR, {24'h0, d});
        wb(1'h0, crs_pkg::REG_DIR, 32'h0);
        chk("dirin", {24'h0, d}, {24'h0, q[7:0]});
        chk("mapped", k ? 32'hFF + 32'(p) * 32'h80 : 32'h7F,
            {16'h0, q[31:16]});
      end
    $display("test direct done");
  endtask
  task automatic t_gp();
    int bk[3];
    bk = '{0, 1, 31};
    for (int i = 0; i < 3; i++)
      for (int x = 0; x < 8; x += 7)
      begin
        wb(1'h1, crs_pkg::REG_PS, 32'(bk[i]) << 11);
        wb(1'h1, crs_pkg::REG_GP, 32'(x));
        wb(1'h0, crs_pkg::REG_GP, 32'h0);
        chk("gpidx", 32'(x), {29'h0, q[2:0]});
        chk("gpaddr", 32'h100 + 32'(bk[i] * 8 + x),
            {16'h0, q[31:16]});
      end
    wb(1'h1, crs_pkg::REG_PS, 32'h45);
    wb(1'h1, crs_pkg::REG_MIRROR, 32'hF9);
    wb(1'h0, crs_pkg::REG_MIRROR, 32'h0);
    chk("mirrorrd", 32'hF9, q);
    wb(1'h0, crs_pkg::REG_PS, 32'h0);
    chk("mirror", 32'hF945, q);
    $display("test banks done");
  endtask
  task automatic t_irq();
    for (int m = 0; m < 4; m++)
      for (int l = 0; l < 4; l++)
        for (int e = 0; e < 2; e++)
        begin
          wb(1'h1, crs_pkg::REG_PS, 32'(e * 64 + m * 16));
          irqReq <= 1'h1;
          irqLevel <= 2'(l);
          repeat (2) @(posedge clk);
          chk("accept", 32'(e && l < m), {31'h0, irqAccept});
          wb(1'h0, crs_pkg::REG_IRQ, 32'h0);
          chk("irqbit", 32'(e && l < m), q);
          irqReq <= 1'h0;
          @(posedge clk);
        end
    $display("test irq done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    {nrst, cyc, stb, we, irqReq} <= 5'h0;
    adr <= 8'h0;
    sel <= 4'hF;
    datI <= 32'h0;
    irqLevel <= 2'h0;
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_alu();
    t_dir();
    t_gp();
    t_irq();
    test_done();
  end
endmodule // crs_regset_tb
